// [testbench/dmcr_bank_checker.sv]
// Port assertions for the mode-control register bank
`timescale 1ns/1ps
module dmcr_bank_checker (
	input wire        core_clk,            // Clock
	input wire        arst_n,              // Reset
	input wire        clk_en,              // Enable
	input wire        cw_valid,            // Word strobe
	input wire [15:0] cw_word,             // Control word
	input wire        word_clock,          // Sample clock
	input wire [7:0]  rd_data_ff,          // Read data
	input wire        rd_valid_ff,         // Read strobe
	input wire [1:0]  deemph_rate_sel,     // Rate field
	input wire        deemph_enable,       // Enable bit
	input wire        deemph_active_ff,    // De-emphasis on
	input wire        phase_invert,        // Polarity
	input wire        output_disable,      // Outputs off
	input wire        single_channel_mode, // Monaural
	input wire        channel_pick,        // Right pick
	input wire [1:0]  modulator_rate_sel,  // Rate code
	input wire        stream_mode_ff,      // Stream mode
	input wire        bipolar_zero_level,  // Zero force
	input wire        single_channel_mode_right_src_ff,   // Right source
	input wire        soft_system_reset,   // Reset pulse
	input wire        os_reserved_ff       // Code 3 flag
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	wire       take = clk_en && cw_valid;
	wire [6:0] idx  = cw_word[14:8];
	sequence s_soft_system_reset_wr;
		take && !cw_word[15] && idx == 7'h14 && cw_word[6];
	endsequence
	sequence s_one_pulse;
		##2 soft_system_reset ##1 !soft_system_reset;
	endsequence
	a_soft_system_reset_pulse: assert property (s_soft_system_reset_wr |-> s_one_pulse)
		else $error("reset pulse wrong");
	a_soft_system_reset_clear: assert property (soft_system_reset |=> !output_disable && modulator_rate_sel == 2'h0)
		else $error("soft reset left state");
	a_read_ans: assert property (take && cw_word[15] |=> rd_valid_ff)
		else $error("read not answered");
	a_read_only: assert property (rd_valid_ff |-> $past(take) && $past(cw_word[15]))
		else $error("stray read strobe");
	a_soft_system_reset_rd0: assert property (rd_valid_ff && $past(idx) == 7'h14 |-> rd_data_ff[7:6] == 2'h0)
		else $error("write-only bit read back");
	a_bpz_force: assert property (output_disable && $past(output_disable) |-> bipolar_zero_level)
		else $error("outputs not forced");
	a_deemph_act: assert property ($stable(deemph_enable) && $stable(deemph_rate_sel) && $stable(stream_mode_ff)
		|-> deemph_active_ff == (deemph_enable && deemph_rate_sel != 2'h0 && !stream_mode_ff))
		else $error("de-emphasis state wrong");
	a_single_channel_mode_src: assert property ($stable(single_channel_mode) && $stable(channel_pick)
		|-> single_channel_mode_right_src_ff == (single_channel_mode && channel_pick))
		else $error("single_channel_mode source wrong");
	a_os_resv: assert property ($stable(modulator_rate_sel) |-> os_reserved_ff == (modulator_rate_sel == 2'h3))
		else $error("reserved code flag wrong");
	a_out_update: assert property ($changed(phase_invert) || $changed(output_disable)
		|-> $past(word_clock) || $past(word_clock, 2) || $past(soft_system_reset) || $past(soft_system_reset, 2))
		else $error("mode changed off boundary");
endmodule // dmcr_bank_checker

bind dmcr_bank dmcr_bank_checker u_chk (.*);

// [testbench/dmcr_host_model.sv]
// Control host model issuing control words
`timescale 1ns/1ps
module dmcr_host_model (
	input  wire        core_clk,    // Clock
	output reg         cw_valid,    // Word strobe
	output reg  [15:0] cw_word,     // Control word
	input  wire        rd_valid_ff, // Read strobe
	input  wire [7:0]  rd_data_ff   // Read data
);
	initial begin
		cw_valid = 1'b0;
		cw_word = 16'hffff;
	end
	// Idle word is inverted so a stale word never looks valid
	task send(input rd, input [6:0] idx, input [7:0] d);
		begin
			@(posedge core_clk);
			cw_valid <= 1'b1;
			cw_word <= {rd, idx, d};
			@(posedge core_clk);
			cw_valid <= 1'b0;
			cw_word <= ~{rd, idx, d};
		end
	endtask
	task get(input [6:0] idx, output [7:0] d, output ok);
		integer n;
		begin
			send(1'b1, idx, 8'h00);
			ok = 1'b0;
			// Answer stands only in the cycle right after the word is taken
			for (n = 0; n < 4 && !ok; n = n + 1) begin
				#1 ok = rd_valid_ff;
				if (!ok)
					@(posedge core_clk);
			end
			d = rd_data_ff;
		end
	endtask
endmodule // dmcr_host_model

// [testbench/tb_top.sv]
// Self-checking bench for the mode-control register bank
`timescale 1ns/1ps
module tb_top;
	reg         core_clk;
	reg         arst_n;
	reg         clk_en;
	reg         word_clock;
	reg         zero_left;
	reg         zero_right;
	wire        cw_valid;
	wire [15:0] cw_word;
	wire [7:0]  rd_data_ff;
	wire        rd_valid_ff;
	wire [15:0] mode_vec;
	wire [7:0]  mute_gain_ff;
	wire [1:0]  fir_perf;
	wire        bipolar_zero_level;
	integer     err_count, comparisons, i, k, r, n;
	reg  [7:0]  sh [0:3];
	reg  [7:0]  d;
	reg         ok;
	dmcr_bank u_dmcr_bank (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .cw_valid(cw_valid),
		.cw_word(cw_word), .word_clock(word_clock), .zero_left(zero_left), .zero_right(zero_right),
		.rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .deemph_rate_sel(mode_vec[15:14]),
		.deemph_enable(mode_vec[13]), .deemph_active_ff(), .fir_perf_sel_ff(fir_perf), .phase_invert(mode_vec[12]),
		.atten_step_rate(mode_vec[11:10]), .output_disable(mode_vec[9]), .bypass_stereo_sel(mode_vec[8]),
		.rolloff_sel(mode_vec[7]), .zero_hold_mute_en(mode_vec[6]), .filter_bypass_en(mode_vec[4]),
		.single_channel_mode(mode_vec[3]), .channel_pick(mode_vec[2]), .modulator_rate_sel(mode_vec[1:0]),
		.stream_mode_ff(mode_vec[5]), .bipolar_zero_level(bipolar_zero_level), .single_channel_mode_right_src_ff(),
		.mute_gain_ff(mute_gain_ff), .soft_system_reset(), .os_reserved_ff());
	dmcr_host_model u_dmcr_host_model (.core_clk(core_clk), .cw_valid(cw_valid), .cw_word(cw_word),
		.rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Scaled sample clock: eight core cycles per sample keeps ramps short
	always begin
		repeat (4) @(posedge core_clk);
		word_clock <= ~word_clock;
	end
	function [15:0] exp_mode(input [7:0] a, input [7:0] b, input [7:0] c);
		exp_mode = {a[3:1], b[7:4], b[2:0], c[5:0]};
	endfunction
	function [7:0] wmask(input integer x);
		wmask = x == 0 ? 8'hff : x == 1 ? 8'hf7 : x == 2 ? 8'h3f : x == 3 ? 8'h07 : 8'h00;
	endfunction
	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, err_count);
			if (err_count == 0 && comparisons > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task fail;
		begin
			err_count = err_count + 1;
			$display("wait limit reached at %0t", $time);
			give_verdict;
		end
	endtask
	task tick;
		begin
			@(posedge core_clk);
			#1;
		end
	endtask
	task wait_wc(input integer cnt);
		integer m;
		reg     wp;
		begin
			wp = word_clock;
			for (m = 0; m < 200 && cnt > 0; m = m + 1) begin
				tick;
				if (word_clock && !wp)
					cnt = cnt - 1;
				wp = word_clock;
			end
			if (cnt > 0)
				fail;
		end
	endtask
	// Counts sample boundaries until the mute gain next moves
	task gain_step(output integer rises);
		integer   m;
		reg [7:0] g0;
		reg       wp;
		begin
			g0 = mute_gain_ff;
			wp = word_clock;
			rises = 0;
			for (m = 0; m < 400 && mute_gain_ff === g0; m = m + 1) begin
				tick;
				if (word_clock && !wp)
					rises = rises + 1;
				wp = word_clock;
			end
			if (m == 400)
				fail;
		end
	endtask
	task wait_gain(input [7:0] tgt);
		integer m;
		begin
			for (m = 0; m < 20000 && mute_gain_ff !== tgt; m = m + 1)
				tick;
			if (m == 20000)
				fail;
		end
	endtask
	task rd(input [6:0] idx, input [7:0] exp);
		begin
			u_dmcr_host_model.get(idx, d, ok);
			check(ok, 1'b1);
			check(d, exp);
		end
	endtask
	initial begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		word_clock = 1'b0;
		zero_left = 1'b0;
		zero_right = 1'b0;
		err_count = 0;
		comparisons = 0;
		k = $urandom(12622);
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		tick;
		rd(7'h12, 8'h50);
		rd(7'h13, 8'h00);
		rd(7'h14, 8'h00);
		rd(7'h15, 8'h01);
		check(mode_vec, 16'h0000);
		check(mute_gain_ff, 8'hff);
		$display("test reset values done");
		sh[0] = 8'h50;
		sh[1] = 8'h00;
		sh[2] = 8'h00;
		sh[3] = 8'h01;
		for (i = 0; i < 30; i = i + 1) begin
			k = i % 5;
			d = $urandom;
			r = (i / 5) % 4;
			if (i < 20)
				d = {d[7], r[1:0], d[4], r[1:0], r[1:0]};
			if (k == 2)
				d[6] = 1'b0;
			// Scaled sample rate is far above 100 kHz, so 128x stays off
			if (k == 2 && d[1:0] == 2'h2)
				d[1] = 1'b0;
			u_dmcr_host_model.send(1'b0, 7'h12 + k[6:0], d);
			if (k < 4)
				sh[k] = d & wmask(k);
			rd(7'h12 + k[6:0], k < 4 ? sh[k] : 8'h00);
			wait_wc(2);
			check(mode_vec, exp_mode(sh[0], sh[1], sh[2]));
			check(fir_perf, sh[2][5] ? sh[0][3:2] : 2'h0);
		end
		$display("test random registers done");
		u_dmcr_host_model.send(1'b0, 7'h14, 8'h40);
		repeat (4) tick;
		check(mode_vec, 16'h0000);
		rd(7'h12, 8'h50);
		rd(7'h14, 8'h00);
		$display("test soft reset done");
		for (r = 0; r < 4; r = r + 1) begin
			u_dmcr_host_model.send(1'b0, 7'h13, {1'b0, r[1:0], 5'h01});
			u_dmcr_host_model.send(1'b0, 7'h12, {7'h28, ~r[0]});
			gain_step(n);
			gain_step(n);
			check(n, 1 << r);
			wait_gain(r[0] ? 8'hff : 8'h00);
			if (r == 2) begin
				@(posedge core_clk);
				zero_left <= 1'b1;
				zero_right <= 1'b1;
				wait_wc(2);
				check(bipolar_zero_level, 1'b1);
				u_dmcr_host_model.send(1'b0, 7'h14, 8'h20);
				wait_wc(2);
				check(bipolar_zero_level, 1'b0);
				u_dmcr_host_model.send(1'b0, 7'h14, 8'h00);
			end
		end
		$display("test soft mute done");
		// A write while the enable is low must be lost
		@(posedge core_clk);
		clk_en <= 1'b0;
		u_dmcr_host_model.send(1'b0, 7'h13, 8'h80);
		@(posedge core_clk);
		clk_en <= 1'b1;
		rd(7'h13, 8'h61);
		$display("test clock enable done");
		give_verdict;
	end
endmodule // tb_top

// [verilog/dmcr_bank.v]
// Mode-control register bank: serial control words, mode outputs
`timescale 1ns/1ps
`include "dmcr_consts.vh"
//
// Operation
// - De-emphasis rate: none, 48, 44.1, 32 kHz
// - Direct-stream mode reuses rate as FIR setting
// - De-emphasis enable applies to both channels
// - Soft mute ramps down, clearing ramps up
// - Soft mute is 256-step attenuation ramp
// - Phase invert flips polarity both channels
// - Step every 1, 2, 4, 8 word clocks
// - Output disable forces bipolar zero level
// - Bypass stereo bit picks single_channel_mode or L/R inputs
// - Rolloff bit: sharp zero, slow one
// - Zero-hold mute holds zero on both-zero once fully muted
// - Zero-hold mute inactive in direct-stream mode
// - System reset write-only, one reset pulse
// - Direct-stream bit selects one-bit input
// - Filter bypass takes external filter data
// - Monaural drives both converters balanced
// - Channel pick matters only in monaural
// - Oversampling 64, 32, 128, reserved
// - Direct-stream mode reuses oversampling as bitclock
// - Top bit zero writes, one reads
// - Word: direction, index, eight data bits
// - Step rate counted in word-clock periods
module dmcr_bank (
	input  wire       core_clk,            // 50 MHz system clock
	input  wire       arst_n,              // Async reset, active low
	input  wire       clk_en,              // Clock enable, freezes state
	input  wire       cw_valid,            // Control word strobe, one cycle
	input  wire [15:0] cw_word,            // Control word from serial port
	input  wire       word_clock,          // Audio word clock, sampled
	input  wire       zero_left,           // Left channel zero detected
	input  wire       zero_right,          // Right channel zero detected
	output reg  [7:0] rd_data_ff,          // Read data
	output reg        rd_valid_ff,         // Read data valid pulse
	output reg  [1:0] deemph_rate_sel,     // De-emphasis rate or FIR perf
	output reg        deemph_enable,       // De-emphasis on
	output reg        deemph_active_ff,    // PCM de-emphasis in force
	output reg  [1:0] fir_perf_sel_ff,     // Stream-mode FIR setting
	output reg        phase_invert,        // Output polarity inverted
	output reg  [1:0] atten_step_rate,     // Attenuation step rate
	output reg        output_disable,      // Outputs forced to zero
	output reg        bypass_stereo_sel,   // Bypass: separate L/R inputs
	output reg        rolloff_sel,         // Slow rolloff when high
	output reg        zero_hold_mute_en,   // Zero-hold mute enable
	output reg        filter_bypass_en,    // External filter mode
	output reg        single_channel_mode, // Monaural mode
	output reg        channel_pick,        // Monaural channel, right high
	output reg  [1:0] modulator_rate_sel,  // Oversampling or bitclock code
	output reg        stream_mode_ff,      // Direct-stream input active
	output reg        bipolar_zero_level,  // Force outputs to mid level
	output reg        single_channel_mode_right_src_ff,   // Monaural source is right
	output reg  [7:0] mute_gain_ff,        // Soft mute gain
	output reg        soft_system_reset,   // Internal reset pulse
	output reg        os_reserved_ff       // Reserved oversampling code
);
	// Shadow registers written by the host
	reg  [7:0] r18_ff;
	reg  [7:0] r19_ff;
	reg  [7:0] r20_ff;
	reg  [7:0] r21_ff;
	reg        wclk_d_ff;
	reg        soft_system_reset_req_ff;
	wire       word_tick;
	wire       wr_req;
	wire       rd_req;
	wire [6:0] idx;
	wire [7:0] wdat;
	wire       step;
	wire [7:0] gain;
	wire       muted;
	reg  [7:0] nxt_rd;

	function [7:0] merge;
		input [7:0] old;
		input [7:0] new_val;
		input [7:0] mask;
		begin
			merge = (old & ~mask) | (new_val & mask);
		end
	endfunction

	assign idx       = cw_word[14:8];
	assign wdat      = cw_word[7:0];
	assign wr_req    = cw_valid && !cw_word[15];
	assign rd_req    = cw_valid && cw_word[15];
	assign word_tick = word_clock && !wclk_d_ff;

	always @* begin
		case (idx)
			`DMCR_IDX_R18: nxt_rd = r18_ff;
			`DMCR_IDX_R19: nxt_rd = r19_ff & `DMCR_R19_WMASK;
			`DMCR_IDX_R20: nxt_rd = r20_ff & `DMCR_R20_RDMASK;
			`DMCR_IDX_R21: nxt_rd = r21_ff & `DMCR_R21_WMASK;
			default:       nxt_rd = 8'h00;
		endcase
	end

	// Host writes and reads
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r18_ff      <= `DMCR_R18_RST;
			r19_ff      <= `DMCR_R19_RST;
			r20_ff      <= `DMCR_R20_RST;
			r21_ff      <= `DMCR_R21_RST;
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
			soft_system_reset_req_ff <= 1'b0;
			wclk_d_ff   <= 1'b0;
		end else if (clk_en) begin
			wclk_d_ff   <= word_clock;
			rd_valid_ff <= rd_req;
			if (rd_req)
				rd_data_ff <= nxt_rd;
			// Set wins, so an SOFT_SYSTEM_RESET write landing on the pulse is not lost
			if (wr_req && idx == `DMCR_IDX_R20 && wdat[`DMCR_SOFT_SYSTEM_RESET_BIT])
				soft_system_reset_req_ff <= 1'b1;
			else if (soft_system_reset)
				soft_system_reset_req_ff <= 1'b0;
			if (soft_system_reset) begin
				r18_ff <= `DMCR_R18_RST;
				r19_ff <= `DMCR_R19_RST;
				r20_ff <= `DMCR_R20_RST;
				r21_ff <= `DMCR_R21_RST;
			end else if (wr_req) begin
				case (idx)
					`DMCR_IDX_R18: r18_ff <= merge(r18_ff, wdat, `DMCR_R18_WMASK);
					`DMCR_IDX_R19: r19_ff <= merge(r19_ff, wdat, `DMCR_R19_WMASK);
					`DMCR_IDX_R20: r20_ff <= merge(r20_ff, wdat, `DMCR_R20_WMASK);
					`DMCR_IDX_R21: r21_ff <= merge(r21_ff, wdat, `DMCR_R21_WMASK);
					default:       r18_ff <= r18_ff;
				endcase
			end
		end
	end

	// One-cycle internal reset pulse
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			soft_system_reset <= 1'b0;
		else if (clk_en)
			soft_system_reset <= soft_system_reset_req_ff && !soft_system_reset;
	end

	// Audio-side copies change only on a word-clock rising edge or a soft reset pulse, so a sample
	// never sees half of a multi-field update.
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			deemph_rate_sel     <= 2'h0;
			deemph_enable       <= 1'b0;
			deemph_active_ff    <= 1'b0;
			fir_perf_sel_ff     <= 2'h0;
			phase_invert        <= 1'b0;
			atten_step_rate     <= 2'h0;
			output_disable      <= 1'b0;
			bypass_stereo_sel   <= 1'b0;
			rolloff_sel         <= 1'b0;
			zero_hold_mute_en   <= 1'b0;
			filter_bypass_en    <= 1'b0;
			single_channel_mode <= 1'b0;
			channel_pick        <= 1'b0;
			modulator_rate_sel  <= `DMCR_OS_X64;
			stream_mode_ff      <= 1'b0;
			single_channel_mode_right_src_ff   <= 1'b0;
			os_reserved_ff      <= 1'b0;
		end else if (clk_en) begin
			if (soft_system_reset) begin
				deemph_rate_sel     <= 2'h0;
				deemph_enable       <= 1'b0;
				deemph_active_ff    <= 1'b0;
				fir_perf_sel_ff     <= 2'h0;
				phase_invert        <= 1'b0;
				atten_step_rate     <= 2'h0;
				output_disable      <= 1'b0;
				bypass_stereo_sel   <= 1'b0;
				rolloff_sel         <= 1'b0;
				zero_hold_mute_en   <= 1'b0;
				filter_bypass_en    <= 1'b0;
				single_channel_mode <= 1'b0;
				channel_pick        <= 1'b0;
				modulator_rate_sel  <= `DMCR_OS_X64;
				stream_mode_ff      <= 1'b0;
				single_channel_mode_right_src_ff   <= 1'b0;
				os_reserved_ff      <= 1'b0;
			end else if (word_tick) begin
				deemph_rate_sel     <= r18_ff[`DMCR_DMF_LSB+1:`DMCR_DMF_LSB];
				deemph_enable       <= r18_ff[`DMCR_DEEN_BIT];
				deemph_active_ff    <= r18_ff[`DMCR_DEEN_BIT] && !r20_ff[`DMCR_DS_BIT]
					&& (r18_ff[`DMCR_DMF_LSB+1:`DMCR_DMF_LSB] != 2'h0);
				fir_perf_sel_ff     <= r20_ff[`DMCR_DS_BIT] ?
					r18_ff[`DMCR_DMF_LSB+1:`DMCR_DMF_LSB] : 2'h0;
				phase_invert        <= r19_ff[`DMCR_REV_BIT];
				atten_step_rate     <= r19_ff[`DMCR_ATS_LSB+1:`DMCR_ATS_LSB];
				output_disable      <= r19_ff[`DMCR_ODIS_BIT];
				bypass_stereo_sel   <= r19_ff[`DMCR_BSTR_BIT];
				rolloff_sel         <= r19_ff[`DMCR_ROLL_BIT];
				zero_hold_mute_en   <= r19_ff[`DMCR_ZHM_BIT];
				filter_bypass_en    <= r20_ff[`DMCR_BYP_BIT];
				single_channel_mode <= r20_ff[`DMCR_SINGLE_CHANNEL_MODE_BIT];
				channel_pick        <= r20_ff[`DMCR_CHSEL_BIT];
				single_channel_mode_right_src_ff   <= r20_ff[`DMCR_SINGLE_CHANNEL_MODE_BIT] && r20_ff[`DMCR_CHSEL_BIT];
				modulator_rate_sel  <= r20_ff[`DMCR_OS_LSB+1:`DMCR_OS_LSB];
				stream_mode_ff      <= r20_ff[`DMCR_DS_BIT];
				// Host must keep 128x off above 100 kHz; not checked here
				os_reserved_ff      <= r20_ff[`DMCR_OS_LSB+1:`DMCR_OS_LSB] == `DMCR_OS_RSVD;
			end
		end
	end

	dmcr_rate_div u_rate_div (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.clk_en    (clk_en),
		.sys_rst   (soft_system_reset),
		.word_tick (word_tick),
		.rate_sel  (atten_step_rate),
		.step_ff   (step)
	);

	dmcr_mute_ramp u_mute_ramp (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.clk_en   (clk_en),
		.sys_rst  (soft_system_reset),
		.mute_req (r18_ff[`DMCR_MUTE_BIT]),
		.step     (step),
		.gain_ff  (gain),
		.muted_ff (muted)
	);

	// Outputs re-registered so each leaves from a flip-flop
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mute_gain_ff       <= `DMCR_ATT_MAX;
			bipolar_zero_level <= 1'b0;
		end else if (clk_en) begin
			mute_gain_ff       <= gain;
			bipolar_zero_level <= output_disable
				|| (zero_hold_mute_en && !stream_mode_ff
					&& zero_left && zero_right && muted);
		end
	end
endmodule // dmcr_bank

// [verilog/dmcr_consts.vh]
// Constants for the converter mode-control register bank
`ifndef DMCR_CONSTS_VH
`define DMCR_CONSTS_VH

`define DMCR_IDX_W          7
`define DMCR_IDX_R18        7'h12
`define DMCR_IDX_R19        7'h13
`define DMCR_IDX_R20        7'h14
`define DMCR_IDX_R21        7'h15

`define DMCR_R18_RST        8'h50
`define DMCR_R19_RST        8'h00
`define DMCR_R20_RST        8'h00
`define DMCR_R21_RST        8'h01

`define DMCR_R18_WMASK      8'hff
`define DMCR_R19_WMASK      8'hf7
`define DMCR_R20_WMASK      8'h3f
`define DMCR_R21_WMASK      8'h07
`define DMCR_R20_RDMASK     8'h3f

// Register 18 fields
`define DMCR_MUTE_BIT       0
`define DMCR_DEEN_BIT       1
`define DMCR_DMF_LSB        2
// Register 19 fields
`define DMCR_ZHM_BIT        0
`define DMCR_ROLL_BIT       1
`define DMCR_BSTR_BIT       2
`define DMCR_ODIS_BIT       4
`define DMCR_ATS_LSB        5
`define DMCR_REV_BIT        7
// Register 20 fields
`define DMCR_OS_LSB         0
`define DMCR_CHSEL_BIT      2
`define DMCR_SINGLE_CHANNEL_MODE_BIT       3
`define DMCR_BYP_BIT        4
`define DMCR_DS_BIT         5
`define DMCR_SOFT_SYSTEM_RESET_BIT       6

`define DMCR_OS_X64         2'h0
`define DMCR_OS_X32         2'h1
`define DMCR_OS_X128        2'h2
`define DMCR_OS_RSVD        2'h3

`define DMCR_ATT_MAX        8'hff
`define DMCR_ATT_ZERO       8'h00
`define DMCR_STEP_CNT_W     3

`endif

// [verilog/dmcr_mute_ramp.v]
// 256-step soft mute attenuation ramp
`timescale 1ns/1ps
`include "dmcr_consts.vh"
module dmcr_mute_ramp (
	input  wire       core_clk,     // System clock
	input  wire       arst_n,       // Async reset, active low
	input  wire       clk_en,       // Clock enable
	input  wire       sys_rst,      // Soft system reset pulse
	input  wire       mute_req,     // Soft mute target
	input  wire       step,         // Ramp step pulse
	output reg  [7:0] gain_ff,      // Mute ramp gain, ff = unity
	output reg        muted_ff      // Fully muted
);
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gain_ff  <= `DMCR_ATT_MAX;
			muted_ff <= 1'b0;
		end else if (clk_en) begin
			if (sys_rst) begin
				gain_ff  <= `DMCR_ATT_MAX;
				muted_ff <= 1'b0;
			end else begin
				if (step && mute_req && gain_ff != `DMCR_ATT_ZERO)
					gain_ff <= gain_ff - 8'h01;
				else if (step && !mute_req && gain_ff != `DMCR_ATT_MAX)
					gain_ff <= gain_ff + 8'h01;
				muted_ff <= (gain_ff == `DMCR_ATT_ZERO);
			end
		end
	end
endmodule // dmcr_mute_ramp

// [verilog/dmcr_rate_div.v]
// Word-clock step divider for attenuation ramp timing
`timescale 1ns/1ps
`include "dmcr_consts.vh"
module dmcr_rate_div (
	input  wire       core_clk,     // System clock
	input  wire       arst_n,       // Async reset, active low
	input  wire       clk_en,       // Clock enable
	input  wire       sys_rst,      // Soft system reset pulse
	input  wire       word_tick,    // One pulse per sample period
	input  wire [1:0] rate_sel,     // Step rate code
	output reg        step_ff       // Step pulse
);
	reg  [`DMCR_STEP_CNT_W-1:0] cnt_ff;
	wire [`DMCR_STEP_CNT_W-1:0] lim;

	assign lim = (3'h1 << rate_sel) - 3'h1;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff  <= 3'h0;
			step_ff <= 1'b0;
		end else if (clk_en) begin
			step_ff <= 1'b0;
			if (sys_rst) begin
				cnt_ff <= 3'h0;
			end else if (word_tick) begin
				if (cnt_ff >= lim) begin
					cnt_ff  <= 3'h0;
					step_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 3'h1;
				end
			end
		end
	end
endmodule // dmcr_rate_div
